// *** rtl/shp_sensor_dev.sv ***
// Sensor end: timing, power modes, ready window and serial slave port
`timescale 1ns/100ps
module shp_sensor_dev
  import shp_pkg::*;
#(
  parameter int MS_OSC_TICKS = MS_OSC_TICKS_DEF,
  parameter int TIMEOUT_STEP_MS = TIMEOUT_STEP_MS_DEF
) (
  input wire logic core_clk,
  input wire logic rst_b,
  shp_link_if.dev link,
  input wire logic [7:0] otp_option,
  input wire logic [7:0] otp_sub_addr,
  input wire logic [15:0] nv_settings,
  input wire logic pir_event,
  input wire logic ch0_event,
  input wire logic ch2_event,
  output logic osc_tick,
  output logic charge_tick,
  output logic sample_tick,
  output logic active_mode,
  output logic window_open
);
  function automatic logic [7:0] period_ms(input logic [1:0] sel);
    case (sel)
      2'h0: period_ms = SP_OPT0_MS;
      2'h1: period_ms = SP_OPT1_MS;
      2'h2: period_ms = SP_OPT2_MS;
      default: period_ms = SP_OPT3_MS;
    endcase
  endfunction

  // ********************************************************
  // Settings capture after reset
  // ********************************************************
  logic loaded_reg, streaming_reg;
  logic [7:0] sub_addr_reg, ptr_reg, shift_reg, pir_to_reg;
  logic [1:0] mult_reg, act_sp_reg, lp_sp_reg;
  logic show_reset_reg, pir_flag_reg, active_reg, window_reg;
  logic wr_en;

  // Straps are caught by the clock after release, never by the reset itself
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      loaded_reg <= 1'b0;
      streaming_reg <= 1'b0;
      sub_addr_reg <= 8'h00;
      mult_reg <= MULT_RST;
      act_sp_reg <= ACT_SP_RST;
      lp_sp_reg <= LP_SP_RST;
      pir_to_reg <= PIR_TO_RST;
    end else if (!loaded_reg) begin
      loaded_reg <= 1'b1;
      streaming_reg <= otp_option[OPT_I2C_BIT];
      sub_addr_reg <= otp_sub_addr;
      if (otp_option[OPT_NV_LOAD_BIT]) begin
        mult_reg <= nv_settings[1:0];
        act_sp_reg <= nv_settings[3:2];
        lp_sp_reg <= nv_settings[5:4];
        pir_to_reg <= nv_settings[15:8];
      end
    end else if (wr_en) begin
      case (ptr_reg)
        REG_PF_SET1: mult_reg <= shift_reg[MULT_LSB +: 2];
        REG_ACT_SP: act_sp_reg <= shift_reg[1:0];
        REG_LP_SP: lp_sp_reg <= shift_reg[1:0];
        REG_PIR_TO: pir_to_reg <= shift_reg;
        default: ;
      endcase
    end
  end

  // ********************************************************
  // Timebase
  // ********************************************************
  // Fractional accumulators give exact average rates from the 100 MHz clock
  logic [6:0] osc_acc_reg, chg_acc_reg;
  logic [15:0] ms_cnt_reg;
  logic [7:0] sp_cnt_reg;
  wire [6:0] osc_sum = osc_acc_reg + 7'(OSC_MHZ);
  wire osc_wrap = osc_sum >= 7'(SYS_CLK_MHZ);
  // Widen before adding one, or the top setting wraps to a zero step
  wire [6:0] chg_step = 7'(CHARGE_BASE_MHZ) * ({5'h00, mult_reg} + 7'h01);
  wire [6:0] chg_sum = chg_acc_reg + chg_step;
  wire chg_wrap = chg_sum >= 7'(SYS_CLK_MHZ);
  wire ms_tick = osc_wrap && ms_cnt_reg == 16'(MS_OSC_TICKS - 1);
  wire [7:0] cur_period = period_ms(active_reg ? act_sp_reg : lp_sp_reg);
  wire samp_now = ms_tick && sp_cnt_reg >= cur_period - 8'h01;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      osc_acc_reg <= 7'h00;
      chg_acc_reg <= 7'h00;
      ms_cnt_reg <= 16'h0000;
      sp_cnt_reg <= 8'h00;
      osc_tick <= 1'b0;
      charge_tick <= 1'b0;
      sample_tick <= 1'b0;
    end else begin
      osc_acc_reg <= osc_wrap ? osc_sum - 7'(SYS_CLK_MHZ) : osc_sum;
      chg_acc_reg <= chg_wrap ? chg_sum - 7'(SYS_CLK_MHZ) : chg_sum;
      osc_tick <= osc_wrap;
      charge_tick <= chg_wrap;
      sample_tick <= samp_now;
      if (osc_wrap) begin
        ms_cnt_reg <= ms_tick ? 16'h0000 : ms_cnt_reg + 16'h0001;
      end
      if (ms_tick) begin
        sp_cnt_reg <= samp_now ? 8'h00 : sp_cnt_reg + 8'h01;
      end
    end
  end

  // ********************************************************
  // Power modes
  // ********************************************************
  logic [7:0] steps_reg;
  logic [15:0] step_ms_reg;
  wire any_event = pir_event | ch0_event | ch2_event;
  wire step_end = ms_tick && step_ms_reg == 16'(TIMEOUT_STEP_MS - 1);
  wire time_up = active_reg && step_end && steps_reg <= 8'h01;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      active_reg <= 1'b0;
      pir_flag_reg <= 1'b0;
      steps_reg <= 8'h00;
      step_ms_reg <= 16'h0000;
    end else begin
      // A fresh event restarts the timer and beats expiry for active_reg; only pir_event keeps pir_flag_reg from clearing
      if (any_event) begin
        active_reg <= 1'b1;
        steps_reg <= pir_to_reg;
        step_ms_reg <= 16'h0000;
      end else if (active_reg && ms_tick) begin
        step_ms_reg <= step_end ? 16'h0000 : step_ms_reg + 16'h0001;
        if (step_end) begin
          steps_reg <= steps_reg - 8'h01;
        end
        if (time_up) begin
          active_reg <= 1'b0;
        end
      end
      if (pir_event) begin
        pir_flag_reg <= 1'b1;
      end else if (time_up) begin
        pir_flag_reg <= 1'b0;
      end
    end
  end
  assign active_mode = active_reg;

  // ********************************************************
  // Link sampling
  // ********************************************************
  logic scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_s1, scl_s2, scl_d, sda_s1, sda_s2, sda_d} <= 6'h3F;
    end else begin
      {scl_s1, scl_s2, scl_d} <= {link.scl, scl_s1, scl_s2};
      {sda_s1, sda_s2, sda_d} <= {link.sda, sda_s1, sda_s2};
    end
  end
  wire scl_rise = scl_s2 && !scl_d;
  wire scl_fall = !scl_s2 && scl_d;
  wire start_det = scl_s2 && scl_d && sda_d && !sda_s2;
  wire stop_det = scl_s2 && scl_d && !sda_d && sda_s2;

  // ********************************************************
  // Ready window
  // ********************************************************
  wire open_now = streaming_reg ? samp_now : any_event;
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      window_reg <= 1'b0;
    end else if (open_now) begin
      window_reg <= 1'b1;
    end else if (stop_det) begin
      window_reg <= 1'b0;
    end
  end
  assign window_open = window_reg;
  // Window is shown by pulling the line low
  assign link.rdy_dev_o = 1'b0;
  assign link.rdy_dev_oe = window_reg;

  // ********************************************************
  // Slave port
  // ********************************************************
  shp_slv_t st_reg;
  logic [3:0] cnt_reg;
  logic rw_reg, sda_oe_reg, scl_oe_reg;
  wire [6:0] my_addr = DEFAULT_ADDR | sub_addr_reg[6:0];
  wire addr_hit = shift_reg[7:1] == my_addr;
  wire byte_done = scl_fall && cnt_reg == 4'h8;
  wire [7:0] ev_byte = 8'(show_reset_reg) << SHOW_RESET_BIT | 8'(pir_flag_reg) << PIR_FLAG_BIT;
  wire [7:0] sf_byte = 8'(active_reg) << OUT_ACTIVE_BIT;
  wire [7:0] rd_val = ptr_reg == REG_EVENT ? ev_byte :
    ptr_reg == REG_SYSFLAG ? sf_byte :
    ptr_reg == REG_PF_SET1 ? 8'({mult_reg, 4'h0}) :
    ptr_reg == REG_ACT_SP ? {6'h00, act_sp_reg} :
    ptr_reg == REG_LP_SP ? {6'h00, lp_sp_reg} :
    ptr_reg == REG_PIR_TO ? pir_to_reg : 8'h00;
  wire first_oe = rw_reg && !rd_val[7];
  shp_slv_t after_hold;
  assign after_hold = rw_reg ? SLV_RD : SLV_CMD;
  assign wr_en = st_reg == SLV_WR && byte_done;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      st_reg <= SLV_IDLE;
      cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      ptr_reg <= 8'h00;
      rw_reg <= 1'b0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else if (start_det) begin
      st_reg <= SLV_ADDR;
      cnt_reg <= 4'h0;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else if (stop_det) begin
      st_reg <= SLV_IDLE;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else begin
      if (scl_rise && cnt_reg != 4'h8) begin
        shift_reg <= {shift_reg[6:0], sda_s2};
        cnt_reg <= cnt_reg + 4'h1;
      end
      case (st_reg)
        SLV_ADDR: if (byte_done) begin
          sda_oe_reg <= addr_hit;
          rw_reg <= shift_reg[0];
          st_reg <= addr_hit ? SLV_ACK_A : SLV_IDLE;
        end
        SLV_ACK_A: if (scl_fall) begin
          cnt_reg <= 4'h0;
          if (!window_reg) begin
            sda_oe_reg <= 1'b0;
            scl_oe_reg <= 1'b1;
            st_reg <= SLV_HOLD;
          end else begin
            sda_oe_reg <= first_oe;
            st_reg <= after_hold;
          end
        end
        // Data must settle before the clock is let go
        SLV_HOLD: if (window_reg) begin
          sda_oe_reg <= first_oe;
          if (sda_oe_reg == first_oe) begin
            scl_oe_reg <= 1'b0;
            st_reg <= after_hold;
          end
        end
        SLV_CMD: if (byte_done) begin
          ptr_reg <= shift_reg;
          sda_oe_reg <= 1'b1;
          st_reg <= SLV_ACK_C;
        end
        SLV_ACK_C, SLV_ACK_W: if (scl_fall) begin
          sda_oe_reg <= 1'b0;
          cnt_reg <= 4'h0;
          st_reg <= SLV_WR;
        end
        SLV_WR: if (byte_done) begin
          ptr_reg <= ptr_reg + 8'h01;
          sda_oe_reg <= 1'b1;
          st_reg <= SLV_ACK_W;
        end
        SLV_RD: if (byte_done) begin
          sda_oe_reg <= 1'b0;
          st_reg <= SLV_RACK;
        end else if (scl_fall) begin
          sda_oe_reg <= !rd_val[~cnt_reg[2:0]];
        end
        SLV_RACK: if (scl_rise) begin
          if (sda_s2) begin
            st_reg <= SLV_IDLE;
          end else begin
            ptr_reg <= ptr_reg + 8'h01;
          end
        end else if (scl_fall) begin
          cnt_reg <= 4'h0;
          sda_oe_reg <= !rd_val[7];
          st_reg <= SLV_RD;
        end
        default: ;
      endcase
    end
  end
  assign link.sda_dev_o = 1'b0;
  assign link.sda_dev_oe = sda_oe_reg;
  assign link.scl_dev_o = 1'b0;
  assign link.scl_dev_oe = scl_oe_reg;

  // ********************************************************
  // Reset indication
  // ********************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      show_reset_reg <= 1'b1;
    end else if (wr_en && ptr_reg == REG_CMD && shift_reg[ACK_RESET_BIT]) begin
      show_reset_reg <= 1'b0;
    end
  end
endmodule // shp_sensor_dev

// *** rtl/shp_pkg.sv ***
// Shared constants and types for the sensor host port and its master
package shp_pkg;
  // ********************************************************
  // Timing
  // ********************************************************
  localparam int SYS_CLK_MHZ = 100;
  localparam int OSC_MHZ = 8;
  localparam int CHARGE_BASE_MHZ = OSC_MHZ / 2;
  localparam int I2C_MAX_KHZ = 400;
  localparam int I2C_QTR_CYCLES = (SYS_CLK_MHZ * 1000 + 4 * I2C_MAX_KHZ - 1) / (4 * I2C_MAX_KHZ);
  localparam int MS_OSC_TICKS_DEF = OSC_MHZ * 1000;
  localparam int TIMEOUT_STEP_MS_DEF = 4200;
  localparam logic [7:0] SP_OPT0_MS = 8'h0A;
  localparam logic [7:0] SP_OPT1_MS = 8'h14;
  localparam logic [7:0] SP_OPT2_MS = 8'h28;
  localparam logic [7:0] SP_OPT3_MS = 8'h50;
  // ********************************************************
  // Device register map and fields
  // ********************************************************
  localparam logic [6:0] DEFAULT_ADDR = 7'h44;
  localparam logic [7:0] REG_EVENT = 8'h10;
  localparam logic [7:0] REG_SYSFLAG = 8'h11;
  localparam logic [7:0] REG_PF_SET1 = 8'h53;
  localparam logic [7:0] REG_CMD = 8'hD0;
  localparam logic [7:0] REG_ACT_SP = 8'hD4;
  localparam logic [7:0] REG_LP_SP = 8'hD5;
  localparam logic [7:0] REG_PIR_TO = 8'hD9;
  localparam int SHOW_RESET_BIT = 7;
  localparam int PIR_FLAG_BIT = 0;
  localparam int OUT_ACTIVE_BIT = 7;
  localparam int MULT_LSB = 4;
  localparam int ACK_RESET_BIT = 0;
  localparam int OPT_NV_LOAD_BIT = 0;
  localparam int OPT_I2C_BIT = 1;
  localparam logic [1:0] MULT_RST = 2'h0;
  localparam logic [1:0] ACT_SP_RST = 2'h0;
  localparam logic [1:0] LP_SP_RST = 2'h3;
  localparam logic [7:0] PIR_TO_RST = 8'h01;
  // ********************************************************
  // Host command registers
  // ********************************************************
  localparam logic [3:0] HR_CTRL = 4'h0;
  localparam logic [3:0] HR_SLAVE = 4'h1;
  localparam logic [3:0] HR_CMD = 4'h2;
  localparam logic [3:0] HR_WDATA = 4'h3;
  localparam logic [3:0] HR_RDATA = 4'h4;
  localparam logic [3:0] HR_STATUS = 4'h5;
  localparam logic [1:0] KIND_WRITE = 2'h0;
  localparam logic [1:0] KIND_RREAD = 2'h1;
  localparam logic [1:0] KIND_CREAD = 2'h2;
  typedef enum logic [3:0] {
    SLV_IDLE, SLV_ADDR, SLV_ACK_A, SLV_HOLD, SLV_CMD, SLV_ACK_C,
    SLV_WR, SLV_ACK_W, SLV_RD, SLV_RACK
  } shp_slv_t;
  typedef enum logic [2:0] {OP_START, OP_TX, OP_RX, OP_STOP, OP_END} shp_op_t;
endpackage

// *** rtl/shp_link_if.sv ***
// Open-drain serial link with ready line between sensor and master
`timescale 1ns/100ps
interface shp_link_if;
  logic scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe, rdy_dev_o, rdy_dev_oe;
  logic scl_host_o, scl_host_oe, sda_host_o, sda_host_oe;
  logic scl, sda, rdy;
  // Pull-ups: a line is low only while some driver enables a low
  assign scl = (scl_dev_oe ? scl_dev_o : 1'b1) & (scl_host_oe ? scl_host_o : 1'b1);
  assign sda = (sda_dev_oe ? sda_dev_o : 1'b1) & (sda_host_oe ? sda_host_o : 1'b1);
  assign rdy = rdy_dev_oe ? rdy_dev_o : 1'b1;
  modport dev (input scl, sda, output scl_dev_o, scl_dev_oe, sda_dev_o, sda_dev_oe,
    rdy_dev_o, rdy_dev_oe);
  modport host (input scl, sda, rdy, output scl_host_o, scl_host_oe, sda_host_o,
    sda_host_oe);
endinterface

// *** rtl/shp_host_ctrl.sv ***
// Master end: register-driven transfer engine for the sensor link
`timescale 1ns/100ps
module shp_host_ctrl
  import shp_pkg::*;
(
  input wire logic core_clk,
  input wire logic rst_b,
  shp_link_if.host link,
  input wire logic [3:0] reg_addr,
  input wire logic [7:0] reg_wdata,
  input wire logic reg_wr,
  input wire logic reg_rd,
  output logic [7:0] reg_rdata
);
  // ********************************************************
  // Transfer scripts
  // ********************************************************
  function automatic shp_op_t op_at(input logic [1:0] kind, input logic [2:0] step);
    op_at = OP_END;
    case (kind)
      KIND_WRITE: op_at = step == 3'h0 ? OP_START : step <= 3'h3 ? OP_TX :
        step == 3'h4 ? OP_STOP : OP_END;
      KIND_RREAD: op_at = step == 3'h0 || step == 3'h3 ? OP_START :
        step <= 3'h4 ? OP_TX : step == 3'h5 ? OP_RX : step == 3'h6 ? OP_STOP : OP_END;
      default: op_at = step == 3'h0 ? OP_START : step == 3'h1 ? OP_TX :
        step == 3'h2 ? OP_RX : step == 3'h3 ? OP_STOP : OP_END;
    endcase
  endfunction

  logic [6:0] slave_reg;
  logic [7:0] cmd_reg, wdata_reg, rdata_reg, rx_reg;
  logic [1:0] kind_reg, ph_reg;
  logic [2:0] step_reg;
  logic [3:0] bit_reg;
  logic [5:0] q_cnt_reg;
  logic busy_reg, nack_reg, sda_oe_reg, scl_oe_reg;
  logic scl_s1, scl_s2, sda_s1, sda_s2, rdy_s1, rdy_s2;

  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      {scl_s1, scl_s2, sda_s1, sda_s2, rdy_s1, rdy_s2} <= 6'h3F;
    end else begin
      {scl_s1, scl_s2} <= {link.scl, scl_s1};
      {sda_s1, sda_s2} <= {link.sda, sda_s1};
      {rdy_s1, rdy_s2} <= {link.rdy, rdy_s1};
    end
  end

  shp_op_t op;
  assign op = op_at(kind_reg, step_reg);
  wire [7:0] tx_byte = step_reg == 3'h2 ? cmd_reg : step_reg == 3'h3 ? wdata_reg :
    {slave_reg, kind_reg == KIND_CREAD || step_reg == 3'h4};
  // Quarter-bit pace rounds up, so SCL never exceeds its limit
  wire q_tick = q_cnt_reg == 6'(I2C_QTR_CYCLES - 1);
  // Waiting for SCL high absorbs the sensor's stretching
  wire adv = busy_reg && q_tick && !(ph_reg == 2'h2 && !scl_s2);
  wire go = reg_wr && reg_addr == HR_CTRL && reg_wdata[0] && !busy_reg;
  wire data_bit = bit_reg != 4'h8;

  // ********************************************************
  // Command registers
  // ********************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      slave_reg <= DEFAULT_ADDR;
      cmd_reg <= 8'h00;
      wdata_reg <= 8'h00;
      kind_reg <= KIND_WRITE;
      reg_rdata <= 8'h00;
    end else begin
      if (reg_wr && !busy_reg) begin
        case (reg_addr)
          HR_CTRL: kind_reg <= reg_wdata[2:1];
          HR_SLAVE: slave_reg <= reg_wdata[6:0];
          HR_CMD: cmd_reg <= reg_wdata;
          HR_WDATA: wdata_reg <= reg_wdata;
          default: ;
        endcase
      end
      if (reg_rd) begin
        case (reg_addr)
          HR_CTRL: reg_rdata <= {5'h00, kind_reg, 1'b0};
          HR_SLAVE: reg_rdata <= {1'b0, slave_reg};
          HR_CMD: reg_rdata <= cmd_reg;
          HR_WDATA: reg_rdata <= wdata_reg;
          HR_RDATA: reg_rdata <= rdata_reg;
          HR_STATUS: reg_rdata <= {5'h00, !rdy_s2, nack_reg, busy_reg};
          default: reg_rdata <= 8'h00;
        endcase
      end
    end
  end

  // ********************************************************
  // Bit engine
  // ********************************************************
  always_ff @(posedge core_clk or negedge rst_b) begin
    if (!rst_b) begin
      q_cnt_reg <= 6'h00;
      busy_reg <= 1'b0;
      nack_reg <= 1'b0;
      ph_reg <= 2'h0;
      step_reg <= 3'h0;
      bit_reg <= 4'h0;
      rx_reg <= 8'h00;
      rdata_reg <= 8'h00;
      sda_oe_reg <= 1'b0;
      scl_oe_reg <= 1'b0;
    end else if (go) begin
      busy_reg <= 1'b1;
      nack_reg <= 1'b0;
      q_cnt_reg <= 6'h00;
      ph_reg <= 2'h0;
      step_reg <= 3'h0;
      bit_reg <= 4'h0;
    end else if (busy_reg) begin
      q_cnt_reg <= q_tick ? 6'h00 : q_cnt_reg + 6'h01;
      if (adv) begin
        ph_reg <= ph_reg + 2'h1;
        case (op)
          OP_START: case (ph_reg)
            2'h0: sda_oe_reg <= 1'b0;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b1;
            default: begin
              scl_oe_reg <= 1'b1;
              step_reg <= step_reg + 3'h1;
            end
          endcase
          OP_TX, OP_RX: case (ph_reg)
            2'h0: sda_oe_reg <= op == OP_TX && data_bit && !tx_byte[~bit_reg[2:0]];
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: begin
              if (op == OP_TX && !data_bit) begin
                nack_reg <= nack_reg | sda_s2;
              end
              if (op == OP_RX && data_bit) begin
                rx_reg <= {rx_reg[6:0], sda_s2};
              end
            end
            default: begin
              scl_oe_reg <= 1'b1;
              bit_reg <= data_bit ? bit_reg + 4'h1 : 4'h0;
              if (!data_bit) begin
                step_reg <= step_reg + 3'h1;
              end
            end
          endcase
          OP_STOP: case (ph_reg)
            2'h0: sda_oe_reg <= 1'b1;
            2'h1: scl_oe_reg <= 1'b0;
            2'h2: sda_oe_reg <= 1'b0;
            default: step_reg <= step_reg + 3'h1;
          endcase
          default: begin
            busy_reg <= 1'b0;
            rdata_reg <= rx_reg;
          end
        endcase
      end
    end
  end
  assign link.sda_host_o = 1'b0;
  assign link.sda_host_oe = sda_oe_reg;
  assign link.scl_host_o = 1'b0;
  assign link.scl_host_oe = scl_oe_reg;
endmodule // shp_host_ctrl

// *** tb/shp_link_properties.sv ***
// Wire-level checks on the sensor link
`timescale 1ns/100ps
module shp_link_properties (
  input wire logic core_clk,
  input wire logic rst_b,
  input wire logic scl,
  input wire logic sda,
  input wire logic rdy,
  input wire logic scl_dev_oe,
  input wire logic sda_dev_oe,
  input wire logic rdy_dev_oe
);
  default clocking @(posedge core_clk); endclocking
  default disable iff (!rst_b);
  ready_drain_a: assert property ($fell(rdy_dev_oe) |-> scl && sda)
    else $error("window closed without a stop on the lines");
  stretch_drain_a: assert property ($rose(scl_dev_oe) |-> $past(rdy))
    else $error("clock held while the window was open");
  data_drain_a: assert property (scl && $past(scl) |-> $stable(sda_dev_oe))
    else $error("device moved data line with clock high");
  ack_start_a: assert property ($rose(sda_dev_oe) |-> !scl)
    else $error("device took data line with clock high");
  ack_end_a: assert property ($fell(sda_dev_oe) |-> !scl)
    else $error("device freed data line with clock high");
  clock_rate_a: assert property ($rose(scl) |-> scl[*8])
    else $error("clock high phase too short");
  stop_close_a: assert property (scl && $past(scl) && $rose(sda) |-> ##[1:8] rdy)
    else $error("window still open after stop");
  stretch_end_a: assert property (scl_dev_oe && !rdy |-> ##[1:8] !scl_dev_oe)
    else $error("stretch kept after window opened");
  cover property ($rose(scl_dev_oe));
  cover property (scl && $past(scl) && $rose(sda));
  cover property ($rose(sda_dev_oe) ##[1:300] $fell(sda_dev_oe));
endmodule // shp_link_properties

// *** tb/sensor_host_port_and_power_modes_tb_top.sv ***
// Bench joining master and sensor ends over the link
`timescale 1ns/100ps
`define CHK(g, e) begin cmp_count++; if ((g) !== (e)) begin miscompares++; \
  $display("unexpected at %0t got %h exp %h", $time, g, e); end end
module sensor_host_port_and_power_modes_tb_top import shp_pkg::*;;
  logic core_clk = 1'h0, rst_b = 1'h0, reg_wr = 1'h0, reg_rd = 1'h0, chk = 1'h0, chk_d = 1'h0;
  logic [3:0] reg_addr = 4'h0;
  logic [7:0] reg_wdata = 8'h0, reg_rdata, otp_sub_addr, wv, st, m, e;
  logic [15:0] nv_settings;
  logic [2:0] ev = 3'h0;
  logic active_mode, osc_tick, charge_tick, win;
  logic [7:0] otp_opt = 8'h03;
  logic [7:0] exp_q[$], msk_q[$];
  int miscompares = 0, cmp_count = 0, cyc = 0, n_osc = 0, n_chg = 0;
  shp_link_if link();
  shp_sensor_dev #(.MS_OSC_TICKS(8), .TIMEOUT_STEP_MS(3)) u_shp_sensor_dev (.core_clk, .rst_b,
    .link, .otp_option(otp_opt), .otp_sub_addr, .nv_settings, .pir_event(ev[0]),
    .ch0_event(ev[1]), .ch2_event(ev[2]), .osc_tick, .charge_tick, .sample_tick(),
    .active_mode, .window_open(win));
  shp_host_ctrl u_shp_host_ctrl (.core_clk, .rst_b, .link, .reg_addr, .reg_wdata, .reg_wr,
    .reg_rd, .reg_rdata);
  shp_link_properties u_shp_link_properties (.core_clk, .rst_b, .scl(link.scl),
    .sda(link.sda), .rdy(link.rdy), .scl_dev_oe(link.scl_dev_oe),
    .sda_dev_oe(link.sda_dev_oe), .rdy_dev_oe(link.rdy_dev_oe));
  initial forever #5 core_clk = ~core_clk;
  task automatic final_report();
    $display("compares %0d miscompares %0d", cmp_count, miscompares);
    if (miscompares == 0 && cmp_count > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask
  // *****
  // Result watcher
  // *****
  always @(posedge core_clk) begin
    cyc++;
    chk_d <= chk;
    if (chk_d) begin
      m = msk_q.pop_front();
      e = exp_q.pop_front();
      `CHK(reg_rdata & m, e)
    end
    // Hang guard, well above the longest expected run
    if (cyc == 95000) begin
      miscompares++;
      final_report();
    end
  end
  task automatic wr(input logic [3:0] a, input logic [7:0] d);
    @(posedge core_clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_wr <= 1'h1;
    @(posedge core_clk);
    reg_wr <= 1'h0;
  endtask
  task automatic rd(input logic [3:0] a, input logic c);
    @(posedge core_clk);
    reg_addr <= a;
    reg_rd <= 1'h1;
    chk <= c;
    @(posedge core_clk);
    reg_rd <= 1'h0;
    chk <= 1'h0;
  endtask
  task automatic xfer(input logic [1:0] k, input logic [7:0] c, input logic [7:0] d);
    wr(HR_CMD, c);
    wr(HR_WDATA, d);
    wr(HR_CTRL, {5'h0, k, 1'h1});
    st = 8'h01;
    while (st[0] !== 1'h0) begin
      rd(HR_STATUS, 1'h0);
      @(posedge core_clk);
      st = reg_rdata;
    end
  endtask
  task automatic nt(input logic [7:0] x);
    exp_q.push_back(x);
    msk_q.push_back(8'hFF);
    rd(HR_RDATA, 1'h1);
  endtask
  task automatic rr(input logic [7:0] a, input logic [7:0] x);
    xfer(KIND_RREAD, a, 8'h00);
    nt(x);
  endtask
  task automatic count_ticks();
    n_osc = 0;
    n_chg = 0;
    repeat (1000) begin
      @(posedge core_clk);
      n_osc += osc_tick;
      n_chg += charge_tick;
    end
  endtask
  // *****
  // Main sequence
  // *****
  initial begin
    // Fixed seed keeps every run repeatable
    wv = 8'($urandom(32'hE4D4));
    otp_sub_addr = 8'($urandom);
    // Slow low-power rate, so some addressing meets a closed window
    nv_settings = {8'h01, 4'h2, wv[3:0]};
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge core_clk);
    wr(HR_SLAVE, {1'h0, DEFAULT_ADDR | otp_sub_addr[6:0]});
    count_ticks();
    `CHK(n_osc, 80)
    `CHK(n_chg, 40 * (wv[1:0] + 1))
    rr(REG_EVENT, 8'h80);
    rr(REG_PF_SET1, {2'h0, wv[1:0], 4'h0});
    xfer(KIND_WRITE, REG_CMD, 8'h01);
    for (int i = 0; i < 3; i++) begin
      @(posedge core_clk);
      ev <= 3'h1 << i;
      @(posedge core_clk);
      ev <= 3'h0;
      repeat (3) @(posedge core_clk);
      `CHK(active_mode, 1'h1)
      repeat (1000) @(posedge core_clk);
      `CHK(active_mode, 1'h0)
    end
    rr(REG_EVENT, 8'h00);
    wv = 8'($urandom) | 8'h01;
    xfer(KIND_WRITE, REG_ACT_SP, wv);
    // A refused last byte leaves the pointer, so the current read sees it again
    rr(REG_ACT_SP, {6'h0, wv[1:0]});
    xfer(KIND_CREAD, 8'h00, 8'h00);
    nt({6'h0, wv[1:0]});
    wr(HR_SLAVE, {1'h0, DEFAULT_ADDR | otp_sub_addr[6:0]} ^ 8'h01);
    xfer(KIND_WRITE, REG_CMD, 8'h00);
    `CHK(st & 8'h03, 8'h02)
    // Second start as a standalone part without stored settings
    otp_opt <= 8'h00;
    rst_b <= 1'h0;
    repeat (2) @(posedge core_clk);
    rst_b <= 1'h1;
    repeat (2) @(posedge core_clk);
    count_ticks();
    `CHK(n_chg, 40)
    @(posedge core_clk);
    ev <= 3'h4;
    @(posedge core_clk);
    ev <= 3'h0;
    repeat (4) @(posedge core_clk);
    `CHK(win, 1'h1)
    exp_q.push_back(8'h04);
    msk_q.push_back(8'h04);
    rd(HR_STATUS, 1'h1);
    repeat (2) @(posedge core_clk);
    final_report();
  end
endmodule // sensor_host_port_and_power_modes_tb_top
